// ===== bsp_defs.svh
// bsp_defs.svh: register offsets, field positions and reset values of the bus-shared port
// assumes: included by the port package and modules by bare name
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH

`define BSP_OFF_DATA 12'h000
`define BSP_OFF_DIR 12'h004
`define BSP_OFF_PULLUP_CONTROL_REG 12'h008
`define BSP_OFF_RDRV 12'h00C
`define BSP_OFF_MODE 12'h010
`define BSP_OFF_EXT 12'h014

`define BSP_PUP_BIT 0
`define BSP_RDP_BIT 0
`define BSP_RDLOCK_BIT 8

`define BSP_DATA_RST 8'h00
`define BSP_DIR_RST 8'h00
`define BSP_PULLUP_CONTROL_REG_RST 8'h00
`define BSP_RDRV_RST 8'h00
`define BSP_MODE_RST 2'h0
`define BSP_WORD_ZERO 32'h0000_0000

`endif

// ===== bsp_pkg.sv
// bsp_pkg.sv: shared types of the bus-shared port
// assumes: bsp_defs.svh holds every numeric constant
`default_nettype none
`include "bsp_defs.svh"

package bsp_pkg;
  // operating mode as seen by the port
  typedef enum logic [1:0] {
    BSP_SINGLE_CHIP,
    BSP_EXPANDED,
    BSP_PERIPHERAL,
    BSP_SPECIAL_SINGLE
  } bsp_mode_t;
endpackage

`default_nettype wire

// ===== bsp_pin_slice.sv
// bsp_pin_slice.sv: per-pin output, enable, pull and drive-strength selection
// assumes: pin inputs synchronous to pclk; pad cell resolves oe/pull/drive
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"

module bsp_pin_slice
  import bsp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic expanded,
  input wire logic [WIDTH-1:0] gpio_out,
  input wire logic [WIDTH-1:0] gpio_dir,
  input wire logic pullup_en,
  input wire logic reduced,
  input wire logic ext_oe,
  input wire logic [WIDTH-1:0] ext_out,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_pullup,
  output logic [WIDTH-1:0] pin_reduced
);
  wire logic [WIDTH-1:0] oe_sel;

  assign oe_sel = expanded ? {WIDTH{ext_oe}} : gpio_dir;
  assign pin_o = expanded ? ext_out : gpio_out;
  assign pin_oe = oe_sel;
  // pull-ups are inactive while the pins carry the external bus
  assign pin_pullup = (expanded || !pullup_en) ? '0 : ~oe_sel;
  assign pin_reduced = reduced ? oe_sel : '0;
endmodule

`default_nettype wire

// ===== bsp_port.sv
// bsp_port.sv: eight-bit port shared between software I/O and the external address/data bus
// assumes: APB slave at 20 MHz, mode supplied by the system, external bus timing outside
//
// What this block does
// - Data register readable and writable at any time while mapped.
// - After reset every general-purpose pin is an input.
// - Expanded modes: pins carry bus; single-chip modes: software I/O.
// - Data register unmapped in expanded and peripheral modes; otherwise always accessible.
// - Each direction bit sets its pin: one output, zero input.
// - Direction register unmapped in expanded or peripheral mode.
// - Direction register resets to all zeros.
// - Pull-up enable pulls input pins high; no effect in expanded modes.
// - Reduced-drive bit lowers drive of all this port's outputs.
// - Drive reduction register accepts only the first write after reset.
// - Drive reduction register unmapped in peripheral mode.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"

module bsp_port
  import bsp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_pullup,
  output logic [WIDTH-1:0] pin_reduced,
  input wire logic ext_oe,
  input wire logic [WIDTH-1:0] ext_out,
  output logic [WIDTH-1:0] ext_in
);
  // elaboration-time refusal of widths the register layout cannot hold
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("bsp_port: WIDTH must be 1..8");
  end

  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] dir_d;
  logic pup_q;
  logic pup_d;
  logic rdp_q;
  logic rdp_d;
  logic rdlock_q;
  logic rdlock_d;
  bsp_mode_t mode_q;
  bsp_mode_t mode_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [WIDTH-1:0] pin_s1_q;
  logic [WIDTH-1:0] pin_s2_q;

  wire logic access;
  wire logic wr;
  wire logic rd;
  wire logic expanded;
  wire logic peripheral;
  wire logic gpio_mapped;
  wire logic hit_data;
  wire logic hit_dir;
  wire logic hit_pullup_control_reg;
  wire logic hit_rdrv;
  wire logic hit_mode;
  wire logic hit_ext;
  wire logic mapped;
  wire logic [WIDTH-1:0] data_view;

  function automatic logic [31:0] zext(input logic [WIDTH-1:0] v);
    logic [31:0] r;
    r = `BSP_WORD_ZERO;
    r[WIDTH-1:0] = v;
    return r;
  endfunction

  assign access = psel && penable;
  assign wr = access && pwrite;
  // read data is captured in the setup cycle so it stands at the access edge
  assign rd = psel && !penable && !pwrite;
  assign expanded = (mode_q == BSP_EXPANDED);
  assign peripheral = (mode_q == BSP_PERIPHERAL);
  assign gpio_mapped = !expanded && !peripheral;
  assign hit_data = (paddr == `BSP_OFF_DATA) && gpio_mapped;
  assign hit_dir = (paddr == `BSP_OFF_DIR) && gpio_mapped;
  assign hit_pullup_control_reg = (paddr == `BSP_OFF_PULLUP_CONTROL_REG);
  assign hit_rdrv = (paddr == `BSP_OFF_RDRV) && !peripheral;
  assign hit_mode = (paddr == `BSP_OFF_MODE);
  assign hit_ext = (paddr == `BSP_OFF_EXT);
  assign mapped = hit_data || hit_dir || hit_pullup_control_reg || hit_rdrv || hit_mode || hit_ext;
  // second sync stage only; first stage feeds nothing else
  assign data_view = (dir_q & data_q) | (~dir_q & pin_s2_q);

  // single-cycle access phase keeps the master simple; unmapped reports an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;
  assign ext_in = pin_s2_q;

  assign data_d = (wr && hit_data) ? pwdata[WIDTH-1:0] : data_q;
  assign dir_d = (wr && hit_dir) ? pwdata[WIDTH-1:0] : dir_q;
  assign pup_d = (wr && hit_pullup_control_reg) ? pwdata[`BSP_PUP_BIT] : pup_q;
  // first write locks the register until the next reset
  assign rdp_d = (wr && hit_rdrv && !rdlock_q) ? pwdata[`BSP_RDP_BIT] : rdp_q;
  assign rdlock_d = rdlock_q || (wr && hit_rdrv);
  assign mode_d = (wr && hit_mode) ? bsp_mode_t'(pwdata[1:0]) : mode_q;

  always_comb begin
    prdata_d = prdata_q;
    if (rd) begin
      prdata_d = `BSP_WORD_ZERO;
      if (hit_data) begin
        prdata_d = zext(data_view);
      end else if (hit_dir) begin
        prdata_d = zext(dir_q);
      end else if (hit_pullup_control_reg) begin
        prdata_d[`BSP_PUP_BIT] = pup_q;
      end else if (hit_rdrv) begin
        prdata_d[`BSP_RDP_BIT] = rdp_q;
        prdata_d[`BSP_RDLOCK_BIT] = rdlock_q;
      end else if (hit_mode) begin
        prdata_d[1:0] = mode_q;
      end else if (hit_ext) begin
        prdata_d = zext(pin_s2_q);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= WIDTH'(`BSP_DATA_RST);
      dir_q <= WIDTH'(`BSP_DIR_RST);
      pup_q <= 1'(`BSP_PULLUP_CONTROL_REG_RST);
      rdp_q <= 1'(`BSP_RDRV_RST);
      rdlock_q <= 1'b0;
      mode_q <= bsp_mode_t'(`BSP_MODE_RST);
      prdata_q <= `BSP_WORD_ZERO;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      pup_q <= pup_d;
      rdp_q <= rdp_d;
      rdlock_q <= rdlock_d;
      mode_q <= mode_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  bsp_pin_slice #(
    .WIDTH(WIDTH)
  ) u_slice (
    .expanded(expanded),
    .gpio_out(data_q),
    .gpio_dir(dir_q),
    .pullup_en(pup_q),
    .reduced(rdp_q),
    .ext_oe(ext_oe),
    .ext_out(ext_out),
    .pin_o(pin_o),
    .pin_oe(pin_oe),
    .pin_pullup(pin_pullup),
    .pin_reduced(pin_reduced)
  );
endmodule

`default_nettype wire

// ===== bsp_port_monitor.sv
// checker for the bus-shared port
// assumes: bound to bsp_port; tracks mode from writes at 0x010
`timescale 1ns/1ps
`default_nettype none
module bsp_port_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_reduced,
  input wire logic ext_oe
);
  logic [1:0] md_q;
  logic lk_q;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // refused writes in peripheral mode must not lock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      md_q <= 2'h0;
      lk_q <= 1'h0;
    end else begin
      if (wr && paddr == 12'h010) md_q <= pwdata[1:0];
      if (wr && paddr == 12'h00C && md_q != 2'h2) lk_q <= 1'h1;
    end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RST: assert property ($rose(presetn) |-> pin_oe == 8'h00)
    else $error("pins not inputs after reset");
  AST_OE: assert property (wr && paddr == 12'h004 && md_q == 2'h0 |=>
    pin_oe == $past(pwdata[7:0])) else $error("direction not applied");
  AST_DATA: assert property (wr && paddr == 12'h000 && md_q == 2'h0 |=>
    (pin_o & pin_oe) == ($past(pwdata[7:0]) & pin_oe)) else $error("data not driven");
  AST_UNMAP: assert property (acc && paddr < 12'h008 && md_q inside {2'h1, 2'h2} |->
    pslverr) else $error("port register mapped");
  AST_RDMAP: assert property (acc && paddr == 12'h00C && md_q == 2'h2 |->
    pslverr) else $error("drive reg mapped");
  AST_EXP: assert property (md_q == 2'h1 |-> pin_oe == {8{ext_oe}} && pin_pullup == 8'h00)
    else $error("bus not on pins");
  AST_PUP: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on output");
  AST_LOCK: assert property (lk_q && wr && paddr == 12'h00C |=> $stable(pin_reduced))
    else $error("drive reg rewritten");
endmodule
`default_nettype wire

// ===== bsp_pad_model.sv
// pads and board outside the port
// assumes: ext_en marks pins some outside circuit drives
`timescale 1ns/1ps
`default_nettype none
module bsp_pad_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_i
);
  // floating unpulled lines show the inverse of the pad value, not a tidy level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl) |
    (~pin_oe & ~ext_en & (pin_pullup | ~pin_o));
endmodule
`default_nettype wire

// ===== tb_bsp_port.sv
// directed APB tests of the bus-shared port
// assumes: port, pad model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_bsp_port;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_oe = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr;
  logic [7:0] pin_i, pin_o, pin_oe, pin_pullup, pin_reduced, ext_in;
  logic [7:0] ext_out = 8'h5A, ext_lvl = 8'h3C, ext_en = 8'hF0;
  int fails = 0, num_checks = 0;
  always #25 pclk = ~pclk;
  bsp_port u_dut (.*);
  bsp_pad_model u_pad (.*);
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    err = pslverr;
    rdata = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
    xfer(a, 1'h0, 32'h0000_0000);
    chk(rdata, e);
    chk({31'h0, err}, {31'h0, x});
  endtask
  task automatic complete_run;
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge pclk);
    fails++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h004, 32'h0000_0000, 1'h0);
    chk(pin_oe, 8'h00);
    xfer(12'h004, 1'h1, 32'h0000_000F);
    xfer(12'h000, 1'h1, 32'h0000_00A5);
    rd(12'h000, 32'h0000_0035, 1'h0);
    chk(pin_oe & pin_o, 8'h05);
    @(posedge pclk);
    ext_en <= 8'h00;
    xfer(12'h008, 1'h1, 32'h0000_0001);
    chk(pin_pullup, 8'hF0);
    xfer(12'h00C, 1'h1, 32'h0000_0001);
    chk(pin_reduced & pin_oe, 8'h0F);
    xfer(12'h00C, 1'h1, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0101, 1'h0);
    rd(12'h000, 32'h0000_00F5, 1'h0);
    rd(12'h014, 32'h0000_00F5, 1'h0);
    chk(ext_in, 8'hF5);
    rd(12'h020, 32'h0000_0000, 1'h1);
    @(posedge pclk);
    ext_oe <= 1'h1;
    xfer(12'h010, 1'h1, 32'h0000_0001);
    chk(pin_oe & pin_o, 8'h5A);
    chk(pin_pullup, 8'h00);
    rd(12'h000, 32'h0000_0000, 1'h1);
    xfer(12'h004, 1'h1, 32'h0000_0000);
    xfer(12'h010, 1'h1, 32'h0000_0002);
    rd(12'h00C, 32'h0000_0000, 1'h1);
    xfer(12'h010, 1'h1, 32'h0000_0000);
    rd(12'h004, 32'h0000_000F, 1'h0);
    xfer(12'h010, 1'h1, 32'h0000_0003);
    rd(12'h004, 32'h0000_000F, 1'h0);
    rd(12'h000, 32'h0000_00F5, 1'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    chk(pin_oe, 8'h00);
    rd(12'h004, 32'h0000_0000, 1'h0);
    xfer(12'h00C, 1'h1, 32'h0000_0000);
    xfer(12'h00C, 1'h1, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0100, 1'h0);
    complete_run;
  end
endmodule
bind bsp_port bsp_port_monitor u_mon (.*);
`default_nettype wire
